// >>> bpr_defs.vh
// Register map, field layout, reset values and timing counts of the bank.
// Functional notes
// - Discharge current code 2, 5, 10, 20 mA.
// - Boost peak code 300mA up to 2.5A.
// - Converter enable bit gates the converter.
// - Converter register resets to 0xc5.
// - Buck stop level is value times 48 mV.
// - Measurement starts only on start bit rising.
// - Frequency code 250k, 500k, 1M, 1.5M.
// - ESR threshold code 50 to 200 mV.
// - Load switch bit enables switch and converter.
// - Input current limit code 1.2A to 6.2A.
// - 500Hz count between levels, high byte first.
// - ESR drop above threshold sets flag bit.
`ifndef BPR_DEFS_VH
`define BPR_DEFS_VH

`define BPR_SLAVE_ADDR 7'h59
`define BPR_OFS_LSWITCH 8'h01
`define BPR_OFS_CONV 8'h02
`define BPR_OFS_BUCK 8'h03
`define BPR_OFS_UPPER 8'h04
`define BPR_OFS_LOWER 8'h05
`define BPR_OFS_FREQ 8'h06
`define BPR_OFS_RES_HI 8'h07
`define BPR_OFS_RES_LO 8'h08
`define BPR_OFS_ESR 8'h09

`define BPR_RST_LSWITCH 8'h38
`define BPR_RST_CONV 8'hc5
`define BPR_RST_BUCK 8'h37
`define BPR_RST_UPPER 8'h46
`define BPR_RST_LOWER 8'h2f
`define BPR_RST_FREQ 8'h01

`define BPR_MASK_LSWITCH 8'h39
`define BPR_MASK_CONV 8'hcf
`define BPR_MASK_FREQ 8'h2f

`define BPR_BIT_SW_ON 0
`define BPR_BIT_CONV_ON 0
`define BPR_BIT_MEAS_START 5

`define BPR_BUCK_STEP_MV 14'd48
`define BPR_LEVEL_STEP_MV 16'd150

`define BPR_CLK_NS 10
`define BPR_TICK_NS 2000000
`define BPR_TICK_CYC (`BPR_TICK_NS / `BPR_CLK_NS)
`define BPR_ESR_PULSE_NS 15000
`define BPR_ESR_CYC (`BPR_ESR_PULSE_NS / `BPR_CLK_NS)

`endif

// >>> bpr_i2c_slave.v
// Serial slave engine: pin filtering, addressing, pointer and byte transfer.
`timescale 1ns/100ps
`include "bpr_defs.vh"
module bpr_i2c_slave (
	input wire core_clk,
	input wire srst,
	input wire scl_in,
	input wire sda_in,
	output reg sda_oe_r,
	output reg [7:0] ptr_r,
	input wire [7:0] rd_data,
	output reg wr_r,
	output reg [7:0] wr_addr_r,
	output reg [7:0] wr_data_r
);
	localparam S_IDLE = 4'd0;
	localparam S_ADDR = 4'd1;
	localparam S_AACK = 4'd2;
	localparam S_PTR = 4'd3;
	localparam S_PACK = 4'd4;
	localparam S_WDAT = 4'd5;
	localparam S_WACK = 4'd6;
	localparam S_RDAT = 4'd7;
	localparam S_RACK = 4'd8;

	wire [1:0] pin_f;
	wire [1:0] pin_fd;
	reg [3:0] st_r;
	reg [3:0] bit_r;
	reg [7:0] sh_r;
	reg rw_r;
	wire scl_f = pin_f[1];
	wire sda_f = pin_f[0];
	wire scl_rise = scl_f & ~pin_fd[1];
	wire scl_fall = ~scl_f & pin_fd[1];
	wire start_ev = scl_f & pin_fd[1] & ~sda_f & pin_fd[0];
	wire stop_ev = scl_f & pin_fd[1] & sda_f & ~pin_fd[0];

	// Three-stage synchronisers; a level is accepted once stages two and
	// three agree, which also rejects single-cycle glitches on the bus.
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_sync
			reg s1_r, s2_r, s3_r, f_r, fd_r;
			always @(posedge core_clk) begin
				if (srst) begin
					s1_r <= 1'b1;
					s2_r <= 1'b1;
					s3_r <= 1'b1;
					f_r <= 1'b1;
					fd_r <= 1'b1;
				end else begin
					s1_r <= g ? scl_in : sda_in;
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) f_r <= s3_r;
					fd_r <= f_r;
				end
			end
			assign pin_f[g] = f_r;
			assign pin_fd[g] = fd_r;
		end
	endgenerate

	// Byte engine: sample on SCL rise, change SDA only on SCL fall.
	always @(posedge core_clk) begin
		if (srst) begin
			st_r <= S_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			rw_r <= 1'b0;
			sda_oe_r <= 1'b0;
			ptr_r <= 8'h00;
			wr_r <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
		end else begin
			wr_r <= 1'b0;
			if (start_ev) begin
				st_r <= S_ADDR;
				bit_r <= 4'h0;
				sda_oe_r <= 1'b0;
			end else if (stop_ev) begin
				st_r <= S_IDLE;
				sda_oe_r <= 1'b0;
			end else if (scl_rise) begin
				case (st_r)
				S_ADDR, S_PTR, S_WDAT: begin
					sh_r <= {sh_r[6:0], sda_f};
					bit_r <= bit_r + 4'h1;
				end
				S_RACK: begin
					if (sda_f) st_r <= S_IDLE; // Master refused more data.
				end
				default: begin
				end
				endcase
			end else if (scl_fall) begin
				case (st_r)
				S_ADDR: begin
					if (bit_r == 4'h8) begin
						if (sh_r[7:1] == `BPR_SLAVE_ADDR) begin
							sda_oe_r <= 1'b1;
							rw_r <= sh_r[0];
							st_r <= S_AACK;
						end else begin
							st_r <= S_IDLE;
						end
					end
				end
				S_AACK, S_RACK: begin
					if (rw_r) begin
						sda_oe_r <= ~rd_data[7];
						sh_r <= {rd_data[6:0], 1'b0};
						bit_r <= 4'h1;
						st_r <= S_RDAT;
					end else begin
						sda_oe_r <= 1'b0;
						bit_r <= 4'h0;
						st_r <= S_PTR;
					end
				end
				S_PTR: begin
					if (bit_r == 4'h8) begin
						ptr_r <= sh_r;
						sda_oe_r <= 1'b1;
						st_r <= S_PACK;
					end
				end
				S_PACK: begin
					sda_oe_r <= 1'b0;
					bit_r <= 4'h0;
					st_r <= S_WDAT;
				end
				S_WDAT: begin
					if (bit_r == 4'h8) begin
						sda_oe_r <= 1'b1;
						st_r <= S_WACK;
					end
				end
				S_WACK: begin
					// The byte is committed as the acknowledge bit ends.
					sda_oe_r <= 1'b0;
					bit_r <= 4'h0;
					wr_r <= 1'b1;
					wr_addr_r <= ptr_r;
					wr_data_r <= sh_r;
					ptr_r <= ptr_r + 8'h01;
					st_r <= S_WDAT;
				end
				S_RDAT: begin
					if (bit_r == 4'h8) begin
						sda_oe_r <= 1'b0;
						ptr_r <= ptr_r + 8'h01;
						st_r <= S_RACK;
					end else begin
						sda_oe_r <= ~sh_r[7];
						sh_r <= {sh_r[6:0], 1'b0};
						bit_r <= bit_r + 4'h1;
					end
				end
				default: begin
					st_r <= S_IDLE;
				end
				endcase
			end
		end
	end
endmodule

// >>> bpr_param_regs.v
// Parameter register bank with field decoders and the measurement sequencer.
`timescale 1ns/100ps
`include "bpr_defs.vh"
module bpr_param_regs #(
	parameter TICK_CYC = `BPR_TICK_CYC
) (
	input wire core_clk,
	input wire srst,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire esr_drop_high,
	input wire str_below_upper,
	input wire str_below_lower,
	output reg switch_on,
	output reg converter_on,
	output reg [4:0] dis_current_ma,
	output reg [11:0] boost_peak_ma,
	output reg [12:0] ilim_ma,
	output reg [10:0] freq_khz,
	output reg [7:0] esr_thr_mv,
	output reg [13:0] buck_stop_mv,
	output reg [15:0] upper_level_mv,
	output reg [15:0] lower_level_mv,
	output reg esr_pulse_on,
	output reg meas_discharge_on,
	output reg meas_busy
);
	localparam M_IDLE = 2'd0;
	localparam M_ESR = 2'd1;
	localparam M_WAIT = 2'd2;
	localparam M_COUNT = 2'd3;
	// Full-width copies first, then cut on purpose to the counter widths.
	localparam [31:0] ESR_CYC_W = `BPR_ESR_CYC;
	localparam [31:0] TICK_LAST_W = TICK_CYC - 1;
	localparam [10:0] ESR_CYC = ESR_CYC_W[10:0];
	localparam [17:0] TICK_LAST = TICK_LAST_W[17:0];

	reg [7:0] load_switch_param_r;
	reg [7:0] converter_param_r;
	reg [7:0] buck_stop_level_r;
	reg [7:0] measure_upper_level_r;
	reg [7:0] measure_lower_level_r;
	reg [7:0] freq_and_esr_cfg_r;
	reg [7:0] result_hi_r;
	reg [7:0] result_lo_r;
	reg esr_fault_r;
	reg start_d_r;
	reg [1:0] mst_r;
	reg [10:0] esr_cnt_r;
	reg [17:0] tick_cnt_r;
	reg [15:0] meas_cnt_r;
	wire [2:0] ana_in = {str_below_lower, str_below_upper, esr_drop_high};
	wire [2:0] afilt;
	reg [7:0] rd_data;
	wire slave_oe;
	wire [7:0] ptr;
	wire wr;
	wire [7:0] wr_addr;
	wire [7:0] wr_data;
	wire start_edge;

	bpr_i2c_slave u_slave (
		.core_clk(core_clk),
		.srst(srst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_oe_r(slave_oe),
		.ptr_r(ptr),
		.rd_data(rd_data),
		.wr_r(wr),
		.wr_addr_r(wr_addr),
		.wr_data_r(wr_data)
	);

	// Field decoders, translating codes into the analog set points.
	function [4:0] dec_dis;
		input [1:0] c;
		case (c)
		2'b00: dec_dis = 5'd2;
		2'b01: dec_dis = 5'd5;
		2'b10: dec_dis = 5'd10;
		default: dec_dis = 5'd20;
		endcase
	endfunction
	function [11:0] dec_boost;
		input [2:0] c;
		case (c)
		3'd0: dec_boost = 12'd300;
		3'd1: dec_boost = 12'd500;
		3'd2: dec_boost = 12'd600;
		3'd3: dec_boost = 12'd800;
		3'd4: dec_boost = 12'd1000;
		3'd5: dec_boost = 12'd1500;
		3'd6: dec_boost = 12'd2000;
		default: dec_boost = 12'd2500;
		endcase
	endfunction
	function [12:0] dec_ilim;
		input [2:0] c;
		case (c)
		3'd0: dec_ilim = 13'd1200;
		3'd1: dec_ilim = 13'd2000;
		3'd2: dec_ilim = 13'd2500;
		3'd3: dec_ilim = 13'd3000;
		3'd4: dec_ilim = 13'd3500;
		3'd5: dec_ilim = 13'd4000;
		3'd6: dec_ilim = 13'd4500;
		default: dec_ilim = 13'd6200;
		endcase
	endfunction
	function [10:0] dec_freq;
		input [1:0] c;
		case (c)
		2'b00: dec_freq = 11'd250;
		2'b01: dec_freq = 11'd500;
		2'b10: dec_freq = 11'd1000;
		default: dec_freq = 11'd1500;
		endcase
	endfunction

	// Analog comparator levels pass three flops, accepted when two agree.
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_async
			reg a1_r, a2_r, a3_r, af_r;
			always @(posedge core_clk) begin
				if (srst) begin
					a1_r <= 1'b0;
					a2_r <= 1'b0;
					a3_r <= 1'b0;
					af_r <= 1'b0;
				end else begin
					a1_r <= ana_in[g];
					a2_r <= a1_r;
					a3_r <= a2_r;
					if (a2_r == a3_r) af_r <= a3_r;
				end
			end
			assign afilt[g] = af_r;
		end
	endgenerate

	// Read mux; unmapped offsets and reserved bits return zero.
	always @* begin
		case (ptr)
		`BPR_OFS_LSWITCH: rd_data = load_switch_param_r;
		`BPR_OFS_CONV: rd_data = converter_param_r;
		`BPR_OFS_BUCK: rd_data = buck_stop_level_r;
		`BPR_OFS_UPPER: rd_data = measure_upper_level_r;
		`BPR_OFS_LOWER: rd_data = measure_lower_level_r;
		`BPR_OFS_FREQ: rd_data = freq_and_esr_cfg_r;
		`BPR_OFS_RES_HI: rd_data = result_hi_r;
		`BPR_OFS_RES_LO: rd_data = result_lo_r;
		`BPR_OFS_ESR: rd_data = {7'h00, esr_fault_r};
		default: rd_data = 8'h00;
		endcase
	end

	// Writable registers; masks drop reserved bits so they stay zero.
	always @(posedge core_clk) begin
		if (srst) begin
			load_switch_param_r <= `BPR_RST_LSWITCH;
			converter_param_r <= `BPR_RST_CONV;
			buck_stop_level_r <= `BPR_RST_BUCK;
			measure_upper_level_r <= `BPR_RST_UPPER;
			measure_lower_level_r <= `BPR_RST_LOWER;
			freq_and_esr_cfg_r <= `BPR_RST_FREQ;
		end else if (wr) begin
			case (wr_addr)
			`BPR_OFS_LSWITCH:
				load_switch_param_r <= wr_data & `BPR_MASK_LSWITCH;
			`BPR_OFS_CONV:
				converter_param_r <= wr_data & `BPR_MASK_CONV;
			`BPR_OFS_BUCK: buck_stop_level_r <= wr_data;
			`BPR_OFS_UPPER: measure_upper_level_r <= wr_data;
			`BPR_OFS_LOWER: measure_lower_level_r <= wr_data;
			`BPR_OFS_FREQ:
				freq_and_esr_cfg_r <= wr_data & `BPR_MASK_FREQ;
			default: begin
			end
			endcase
		end
	end

	// Only a fresh 0-to-1 of the start bit launches a measurement.
	assign start_edge = freq_and_esr_cfg_r[`BPR_BIT_MEAS_START] & ~start_d_r;

	// Measurement sequencer: ESR pulse, wait for upper level, then count
	// 500Hz ticks until the lower level. Starts while busy are ignored,
	// and the counter saturates rather than wrapping on a stalled cell.
	always @(posedge core_clk) begin
		if (srst) begin
			start_d_r <= 1'b0;
			mst_r <= M_IDLE;
			esr_cnt_r <= 11'h000;
			tick_cnt_r <= 18'h00000;
			meas_cnt_r <= 16'h0000;
			result_hi_r <= 8'h00;
			result_lo_r <= 8'h00;
			esr_fault_r <= 1'b0;
		end else begin
			start_d_r <= freq_and_esr_cfg_r[`BPR_BIT_MEAS_START];
			case (mst_r)
			M_IDLE: begin
				if (start_edge) begin
					esr_fault_r <= 1'b0;
					esr_cnt_r <= 11'h000;
					mst_r <= M_ESR;
				end
			end
			M_ESR: begin
				if (esr_cnt_r == ESR_CYC - 11'h001) begin
					// Drop above threshold flags the cell as worn.
					if (afilt[0]) esr_fault_r <= 1'b1;
					mst_r <= M_WAIT;
				end else begin
					esr_cnt_r <= esr_cnt_r + 11'h001;
				end
			end
			M_WAIT: begin
				tick_cnt_r <= 18'h00000;
				meas_cnt_r <= 16'h0000;
				if (afilt[1]) mst_r <= M_COUNT;
			end
			M_COUNT: begin
				if (afilt[2]) begin
					result_hi_r <= meas_cnt_r[15:8];
					result_lo_r <= meas_cnt_r[7:0];
					mst_r <= M_IDLE;
				end else if (tick_cnt_r == TICK_LAST) begin
					tick_cnt_r <= 18'h00000;
					if (meas_cnt_r != 16'hffff)
						meas_cnt_r <= meas_cnt_r + 16'h0001;
				end else begin
					tick_cnt_r <= tick_cnt_r + 18'h00001;
				end
			end
			default: mst_r <= M_IDLE;
			endcase
		end
	end

	// Registered analog controls, updated the cycle after each write.
	always @(posedge core_clk) begin
		if (srst) begin
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			switch_on <= 1'b0;
			converter_on <= 1'b0;
			dis_current_ma <= 5'd0;
			boost_peak_ma <= 12'd0;
			ilim_ma <= 13'd0;
			freq_khz <= 11'd0;
			esr_thr_mv <= 8'd0;
			buck_stop_mv <= 14'd0;
			upper_level_mv <= 16'd0;
			lower_level_mv <= 16'd0;
			esr_pulse_on <= 1'b0;
			meas_discharge_on <= 1'b0;
			meas_busy <= 1'b0;
		end else begin
			sda_out <= 1'b0; // Open drain: only ever pulls low.
			sda_oe <= slave_oe;
			switch_on <= load_switch_param_r[`BPR_BIT_SW_ON];
			converter_on <= load_switch_param_r[`BPR_BIT_SW_ON] &
				converter_param_r[`BPR_BIT_CONV_ON];
			dis_current_ma <= dec_dis(converter_param_r[7:6]);
			boost_peak_ma <= dec_boost(converter_param_r[3:1]);
			ilim_ma <= dec_ilim(load_switch_param_r[5:3]);
			freq_khz <= dec_freq(freq_and_esr_cfg_r[1:0]);
			// Threshold steps of 50 mV per code, starting at 50.
			esr_thr_mv <= {1'b0, freq_and_esr_cfg_r[3:2], 5'h00} +
				{2'b00, freq_and_esr_cfg_r[3:2], 4'h0} +
				{5'h00, freq_and_esr_cfg_r[3:2], 1'b0} + 8'd50;
			buck_stop_mv <= `BPR_BUCK_STEP_MV *
				{6'h00, buck_stop_level_r};
			upper_level_mv <= `BPR_LEVEL_STEP_MV *
				{8'h00, measure_upper_level_r};
			lower_level_mv <= `BPR_LEVEL_STEP_MV *
				{8'h00, measure_lower_level_r};
			esr_pulse_on <= (mst_r == M_ESR);
			meas_discharge_on <= (mst_r == M_WAIT) | (mst_r == M_COUNT);
			meas_busy <= (mst_r != M_IDLE);
		end
	end
endmodule

// >>> bpr_checker.sv
// Port-level property checker for the parameter register bank.
`timescale 1ns/100ps
`include "bpr_defs.vh"
module bpr_checker #(
	parameter TICK_CYC = 10
) (
	input logic core_clk,
	input logic srst,
	input logic switch_on,
	input logic converter_on,
	input logic [4:0] dis_current_ma,
	input logic [11:0] boost_peak_ma,
	input logic [12:0] ilim_ma,
	input logic [10:0] freq_khz,
	input logic [7:0] esr_thr_mv,
	input logic [13:0] buck_stop_mv,
	input logic [15:0] upper_level_mv,
	input logic [15:0] lower_level_mv,
	input logic esr_pulse_on,
	input logic meas_discharge_on,
	input logic meas_busy
);
	logic [1:0] up_r;
	logic [11:0] esr_len_r;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// Decoded outputs only hold table values once the reset pipeline drains.
	always @(posedge core_clk) begin
		if (srst) begin
			up_r <= 2'd0;
		end else if (up_r != 2'd2) begin
			up_r <= up_r + 2'd1;
		end
	end
	// Length of the current ESR pulse in clocks.
	always @(posedge core_clk) begin
		if (srst || !esr_pulse_on) begin
			esr_len_r <= 12'd0;
		end else begin
			esr_len_r <= esr_len_r + 12'd1;
		end
	end
	property p_dis_code;
		up_r == 2'd2 |-> dis_current_ma inside {5'd2, 5'd5, 5'd10, 5'd20};
	endproperty
	a_dis_code: assert property (p_dis_code)
		else $error("discharge current off table");
	property p_boost_code;
		up_r == 2'd2 |-> boost_peak_ma inside {12'd300, 12'd500, 12'd600,
			12'd800, 12'd1000, 12'd1500, 12'd2000, 12'd2500};
	endproperty
	a_boost_code: assert property (p_boost_code)
		else $error("boost peak off table");
	property p_ilim_code;
		up_r == 2'd2 |-> ilim_ma inside {13'd1200, 13'd2000, 13'd2500,
			13'd3000, 13'd3500, 13'd4000, 13'd4500, 13'd6200};
	endproperty
	a_ilim_code: assert property (p_ilim_code)
		else $error("current limit off table");
	property p_freq_code;
		up_r == 2'd2 |-> freq_khz inside {11'd250, 11'd500, 11'd1000, 11'd1500};
	endproperty
	a_freq_code: assert property (p_freq_code)
		else $error("frequency off table");
	property p_esr_code;
		up_r == 2'd2 |-> esr_thr_mv inside {8'd50, 8'd100, 8'd150, 8'd200};
	endproperty
	a_esr_code: assert property (p_esr_code)
		else $error("esr threshold off table");
	property p_conv_gate;
		converter_on |-> switch_on;
	endproperty
	a_conv_gate: assert property (p_conv_gate)
		else $error("converter on with switch off");
	property p_buck_step;
		buck_stop_mv % 48 == 0;
	endproperty
	a_buck_step: assert property (p_buck_step)
		else $error("buck level not a 48 mV step");
	property p_level_step;
		upper_level_mv % 150 == 0 && lower_level_mv % 150 == 0;
	endproperty
	a_level_step: assert property (p_level_step)
		else $error("measure level not a 150 mV step");
	property p_busy_start;
		$rose(meas_busy) |-> esr_pulse_on && !meas_discharge_on;
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("measurement did not open with esr pulse");
	property p_esr_len;
		$fell(esr_pulse_on) |-> esr_len_r == `BPR_ESR_CYC;
	endproperty
	a_esr_len: assert property (p_esr_len)
		else $error("esr pulse length wrong");
endmodule
bind bpr_param_regs bpr_checker #(.TICK_CYC(TICK_CYC)) u_chk (.core_clk,
	.srst, .switch_on, .converter_on, .dis_current_ma, .boost_peak_ma,
	.ilim_ma, .freq_khz, .esr_thr_mv, .buck_stop_mv, .upper_level_mv,
	.lower_level_mv, .esr_pulse_on, .meas_discharge_on, .meas_busy);

// >>> bpr_host.sv
// Serial bus host model that drives the clock and data lines.
`timescale 1ns/100ps
module bpr_host (
	input logic core_clk,
	input logic sda,
	output logic scl,
	output logic sda_oe,
	output logic rd_done,
	output logic [7:0] rd_byte
);
	logic [7:0] wbuf [0:7];
	// Idle bus: clock high, data released to the pull-up.
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
		rd_done = 1'b0;
		rd_byte = 8'h00;
	end
	task automatic q(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Start condition; phases last eight core clocks or more.
	task automatic start();
		sda_oe = 1'b0;
		q(8);
		scl = 1'b1;
		q(12);
		sda_oe = 1'b1;
		q(12);
		scl = 1'b0;
		q(8);
	endtask
	task automatic stop();
		sda_oe = 1'b1;
		q(8);
		scl = 1'b1;
		q(12);
		sda_oe = 1'b0;
		q(12);
	endtask
	// Eight bits MSB first plus acknowledge; data moves only with clock low.
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_oe = !tx[i];
			q(8);
			scl = 1'b1;
			q(6);
			rx[i] = sda;
			q(6);
			scl = 1'b0;
			q(8);
		end
	endtask
	task automatic wr(input logic [7:0] dev, input logic [7:0] a,
		input int n, output logic nak);
		logic [8:0] r;
		start();
		xfer({dev, 1'b1}, r);
		nak = r[0];
		for (int k = 0; k <= n; k++) begin
			xfer({(k == 0) ? a : wbuf[k - 1], 1'b1}, r);
			nak = nak | r[0];
		end
		stop();
	endtask
	// Pointer write, repeated start, then n bytes; the last one is refused.
	task automatic rd(input logic [7:0] a, input int n, output logic nak);
		logic [8:0] r;
		start();
		xfer({8'hb2, 1'b1}, r);
		nak = r[0];
		xfer({a, 1'b1}, r);
		nak = nak | r[0];
		start();
		xfer({8'hb3, 1'b1}, r);
		nak = nak | r[0];
		for (int k = 1; k <= n; k++) begin
			xfer({8'hff, k == n}, r);
			rd_byte = r[8:1];
			rd_done = 1'b1;
			q(1);
			rd_done = 1'b0;
		end
		stop();
	endtask
endmodule

// >>> bpr_tb.sv
// Self-checking bench for the parameter register bank.
`timescale 1ns/100ps
module testbench;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic esr_drop_high = 1'b0;
	logic str_below_upper = 1'b0;
	logic str_below_lower = 1'b0;
	logic scl_in, host_oe, rd_done, nak, sda_out, sda_oe, switch_on;
	logic converter_on, esr_pulse_on, meas_discharge_on, meas_busy;
	logic [7:0] rd_byte, esr_thr_mv;
	logic [4:0] dis_current_ma;
	logic [11:0] boost_peak_ma;
	logic [12:0] ilim_ma;
	logic [10:0] freq_khz;
	logic [13:0] buck_stop_mv;
	logic [15:0] upper_level_mv, lower_level_mv;
	logic [7:0] rv [1:6];
	logic [7:0] msk [1:6] = '{8'h39, 8'hcf, 8'hff, 8'hff, 8'hff, 8'h2f};
	int t_dis [4] = '{2, 5, 10, 20};
	int t_bst [8] = '{300, 500, 600, 800, 1000, 1500, 2000, 2500};
	int t_lim [8] = '{1200, 2000, 2500, 3000, 3500, 4000, 4500, 6200};
	int t_frq [4] = '{250, 500, 1000, 1500};
	int mismatches = 0;
	int num_checks = 0;
	int n;
	logic [7:0] expq [$];
	wire sda_in = !(host_oe | sda_oe);
	bpr_host u_host (.core_clk, .sda(sda_in), .scl(scl_in),
		.sda_oe(host_oe), .rd_done, .rd_byte);
	bpr_param_regs #(.TICK_CYC(10)) u_dut (.core_clk, .srst, .scl_in,
		.sda_in, .sda_out, .sda_oe, .esr_drop_high, .str_below_upper,
		.str_below_lower, .switch_on, .converter_on, .dis_current_ma,
		.boost_peak_ma, .ilim_ma, .freq_khz, .esr_thr_mv, .buck_stop_mv,
		.upper_level_mv, .lower_level_mv, .esr_pulse_on,
		.meas_discharge_on, .meas_busy);
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic q(input int k);
		repeat (k) @(negedge core_clk);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic tmo(input int lim);
		if (n >= lim) begin
			$display("[FAIL] %0t wait timed out", $time);
			mismatches++;
			give_verdict();
		end
	endtask
	// Each byte the host reads is matched with the oldest note.
	always @(posedge core_clk) begin
		if (rd_done === 1'b1) begin
			chk(rd_byte, (expq.size() > 0) ? expq.pop_front() : 8'hxx);
		end
	end
	// Register values must show at the decoded outputs.
	task automatic chk_dec();
		q(4);
		chk(switch_on, rv[1][0]);
		chk(converter_on, rv[1][0] & rv[2][0]);
		chk(dis_current_ma, t_dis[rv[2][7:6]]);
		chk(boost_peak_ma, t_bst[rv[2][3:1]]);
		chk(ilim_ma, t_lim[rv[1][5:3]]);
		chk(freq_khz, t_frq[rv[6][1:0]]);
		chk(esr_thr_mv, 50 * (rv[6][3:2] + 1));
		chk(buck_stop_mv, rv[3] * 48);
		chk(upper_level_mv, rv[4] * 150);
		chk(lower_level_mv, rv[5] * 150);
	endtask
	task automatic wr_regs();
		for (int k = 0; k < 6; k++) u_host.wbuf[k] = rv[k + 1];
		u_host.wr(8'hb2, 8'h01, 6, nak);
		chk(nak, 1'b0);
	endtask
	task automatic wr1(input logic [7:0] a, input logic [7:0] d);
		u_host.wbuf[0] = d;
		u_host.wr(8'hb2, a, 1, nak);
	endtask
	task automatic rd_regs();
		for (int k = 1; k <= 6; k++) expq.push_back(rv[k] & msk[k]);
		u_host.rd(8'h01, 6, nak);
		chk(nak, 1'b0);
	endtask
	// Reset, then defaults at the outputs and in the registers.
	task automatic reset_check();
		srst = 1'b1;
		q(3);
		srst = 1'b0;
		rv = '{8'h38, 8'hc5, 8'h37, 8'h46, 8'h2f, 8'h01};
		chk_dec();
		chk(meas_busy, 1'b0);
		rd_regs();
	endtask
	initial begin
		#1000000;
		$display("[FAIL] %0t run limit reached", $time);
		mismatches++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h33544b1d));
		reset_check();
		// Every 3-bit table code once and every 2-bit code twice, random reserved and enable bits around it.
		for (int i = 0; i < 8; i++) begin
			for (int k = 1; k <= 6; k++) rv[k] = 8'($urandom);
			rv[1][5:3] = i[2:0];
			rv[2][3:1] = i[2:0];
			rv[2][7:6] = i[1:0];
			rv[6][3:0] = {~i[1:0], i[1:0]};
			rv[6][5] = 1'b0;
			wr_regs();
			chk_dec();
			rd_regs();
		end
		u_host.wbuf[0] = 8'h00;
		u_host.wr(8'ha0, 8'h02, 1, nak);
		chk(nak, 1'b1);
		chk_dec();
		// Measurement with a high ESR drop and a 25.5 tick discharge.
		esr_drop_high = 1'b1;
		rv[6][5] = 1'b1;
		wr1(8'h06, rv[6]);
		for (n = 0; n < 200 && meas_busy !== 1'b1; n++) q(1);
		tmo(200);
		chk(esr_pulse_on, 1'b1);
		for (n = 0; n < 2000 && esr_pulse_on !== 1'b0; n++) q(1);
		tmo(2000);
		esr_drop_high = 1'b0;
		q(10);
		chk(meas_discharge_on, 1'b1);
		q(20);
		str_below_upper = 1'b1;
		q(255);
		str_below_lower = 1'b1;
		for (n = 0; n < 200 && meas_busy !== 1'b0; n++) q(1);
		tmo(200);
		wr1(8'h07, 8'h5a);
		expq = '{8'h00, 8'h19, 8'h01, 8'h00, 8'h00};
		u_host.rd(8'h07, 5, nak);
		// A second set without clearing first must not restart.
		str_below_upper = 1'b0;
		str_below_lower = 1'b0;
		wr1(8'h06, rv[6]);
		q(20);
		chk(meas_busy, 1'b0);
		wr1(8'h06, rv[6] & 8'hdf);
		wr1(8'h06, rv[6]);
		q(20);
		chk(meas_busy, 1'b1);
		expq.push_back(8'h00);
		u_host.rd(8'h09, 1, nak);
		reset_check();
		q(20);
		give_verdict();
	end
endmodule
